// ---- src/apscs_pkg.sv ----
// shared constants and types for the paired-input converter sequencer
// Operation
// - each sample-and-hold acquires over exactly two converter clocks after its trigger
// - a trigger posts a pending request, converted when the converter frees
// - both channels of a pair always convert; idle pair sequence is 24 clocks, 26 with seq 1, order 0
// - channel conversion: sample, attach to converter, store result at end
// - dedicated sample-and-hold samples on trigger regardless of sequencing bits
// - shared sample-and-hold samples after previous conversion, waits while occupied
// - simultaneous pair requests are served lowest pair number first
// - order bit 0 converts the even channel of a pair first
// - order bit 1 converts the odd channel of a pair first
// - seq 0, order 0: pair conversions run 0, 1, 2, 3
// - seq 0, order 1: conversions run 1, 0, 3, 2
// - seq 1, order 0: odd channel samples only after even conversion ends
// - seq 1, order 1: conversions run 1, 0, 3, 2 with 3 sampled early
// - results kept as 10 bits, read as 16-bit word formatted by control bit 8
// - straight binary code, all zeros to all ones over the reference span
// - conversion order bit sits at control bit 6
// - sequential sample enable bit sits at control bit 5
// - format value 0 reads results as integers
// - a finished sequence never repeats; each new sequence needs a trigger
package apscs_pkg;

	localparam int unsigned RESULT_W        = 10;
	localparam int unsigned BUS_W           = 16;
	localparam int unsigned CTRL_W          = 16;
	localparam int unsigned FRAC_PAD        = BUS_W - RESULT_W;
	localparam int unsigned CTRL_ON_BIT     = 15;
	localparam int unsigned CTRL_FORMAT_BIT = 8;
	localparam int unsigned CTRL_ORDER_BIT  = 6;
	localparam int unsigned CTRL_SEQ_BIT    = 5;
	localparam int unsigned CTRL_DIV_LSB    = 0;
	localparam int unsigned DIV_W           = 3;
	localparam int unsigned SAMPLE_CLKS     = 2;
	localparam int unsigned CONNECT_CLKS    = 1;
	localparam int unsigned TRIAL_CLKS      = RESULT_W;
	localparam int unsigned PAIR_CLKS       = 24;
	localparam int unsigned DEF_PAIRS       = 4;
	localparam int unsigned BIT_IDX_W       = 4;
	localparam logic        FORMAT_INTEGER  = 1'b0;
	localparam logic [RESULT_W-1:0] TRIAL_FIRST = 10'h200;
	localparam logic [DIV_W-1:0]    DIV_RESET   = 3'h0;

	typedef enum logic [0:0] {
		CONV_IDLE  = 1'b0,
		CONV_TRIAL = 1'b1
	} apscs_conv_state_t;

endpackage

// ---- src/apscs_core.sv ----
// pair sample and conversion sequencer with result formatting
`timescale 1ns/1ps
`default_nettype none

module apscs_core
	import apscs_pkg::*;
#(
	parameter int unsigned NUM_PAIRS = DEF_PAIRS
) (
	input  wire logic                             sys_clk,
	input  wire logic                             sys_rst,
	input  wire logic [CTRL_W-1:0]                converter_control_reg,
	input  wire logic [NUM_PAIRS-1:0]             pair_trigger,
	input  wire logic [NUM_PAIRS-1:0]             pair_ready_clear,
	input  wire logic                             comp_in,
	input  wire logic                             rd_en,
	input  wire logic [$clog2(2*NUM_PAIRS)-1:0]   rd_sel,
	output logic      [BUS_W-1:0]                 rd_data,
	output logic                                  rd_valid,
	output logic      [2*NUM_PAIRS-1:0]           sample_hold_en,
	output logic      [$clog2(2*NUM_PAIRS)-1:0]   conv_chan_sel,
	output logic      [RESULT_W-1:0]              sar_trial_code,
	output logic                                  conv_busy,
	output logic      [NUM_PAIRS-1:0]             pair_pending,
	output logic      [NUM_PAIRS-1:0]             pair_ready_status
);

	localparam int unsigned NUM_CH = 2 * NUM_PAIRS;
	localparam int unsigned CH_W   = $clog2(NUM_CH);
	localparam int unsigned PAIR_W = CH_W - 1;
	localparam int unsigned SCNT_W = $clog2(SAMPLE_CLKS);

	if (NUM_PAIRS < 2 || (NUM_PAIRS & (NUM_PAIRS - 1)) != 0) begin : g_bad_pairs
		$error("NUM_PAIRS must be a power of two, at least 2");
	end
	if (SAMPLE_CLKS + 2 * (CONNECT_CLKS + TRIAL_CLKS) != PAIR_CLKS) begin : g_bad_timing
		$error("pair timing constants are inconsistent");
	end

	// control fields
	logic             module_on;
	logic             result_format_sel;
	logic             conv_order_sel;
	logic             sequential_sample_en;
	logic [DIV_W-1:0] conv_clock_div_sel;

	assign module_on            = converter_control_reg[CTRL_ON_BIT];
	assign result_format_sel    = converter_control_reg[CTRL_FORMAT_BIT];
	assign conv_order_sel       = converter_control_reg[CTRL_ORDER_BIT];
	assign sequential_sample_en = converter_control_reg[CTRL_SEQ_BIT];
	assign conv_clock_div_sel   = converter_control_reg[CTRL_DIV_LSB +: DIV_W];

	// switching the module off aborts everything in flight, like a reset
	logic clr;
	assign clr = sys_rst | ~module_on;

	// converter clock as an enable pulse
	logic [DIV_W-1:0] div_cnt_reg;
	logic             tick;

	assign tick = (div_cnt_reg == conv_clock_div_sel);

	always_ff @(posedge sys_clk) begin
		if (clr || tick)
			div_cnt_reg <= DIV_RESET;
		else
			div_cnt_reg <= div_cnt_reg + 1'b1;
	end

	// comparator decision comes from the analog side, so it is synchronised
	logic comp_meta_reg;
	logic comp_sync_reg;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end else begin
			comp_meta_reg <= comp_in;
			comp_sync_reg <= comp_meta_reg;
		end
	end

	// sequencing state
	apscs_conv_state_t    state_reg;
	logic [NUM_PAIRS-1:0] pend_reg;
	logic [NUM_CH-1:0]    need_reg;
	logic [NUM_CH-1:0]    samp_reg;
	logic [NUM_CH-1:0]    held_reg;
	logic [NUM_CH-1:0]    samp_end;
	logic                 shared_busy_reg;
	logic                 active_reg;
	logic                 second_reg;
	logic [PAIR_W-1:0]    cur_pair_reg;
	logic [CH_W-1:0]      chan_reg;
	logic [BIT_IDX_W-1:0] bit_idx_reg;
	logic [RESULT_W-1:0]  trial_reg;
	logic [RESULT_W-1:0]  trial_next;
	logic [RESULT_W-1:0]  result_buffer [NUM_CH];
	logic [NUM_PAIRS-1:0] ready_reg;

	logic [NUM_PAIRS-1:0] trig_ok;
	logic                 any_pend;
	logic [PAIR_W-1:0]    low_pair;
	logic [PAIR_W-1:0]    sel_pair;
	logic [CH_W-1:0]      tgt_chan;
	logic                 start_conv;
	logic                 done_chan;
	logic                 pair_done;
	logic                 sh_any;
	logic [PAIR_W-1:0]    sh_pick;
	logic                 sh_grant;

	// a pair already in flight ignores a retrigger until it completes
	assign trig_ok = pair_trigger & ~pend_reg;

	// lowest pending pair wins
	always_comb begin
		any_pend = 1'b0;
		low_pair = '0;
		for (int p = NUM_PAIRS - 1; p >= 0; p--) begin
			if (pend_reg[p]) begin
				any_pend = 1'b1;
				low_pair = PAIR_W'(p);
			end
		end
	end

	assign sel_pair = active_reg ? cur_pair_reg : low_pair;
	// odd channel first when the order bit is set
	assign tgt_chan = {sel_pair, conv_order_sel ^ second_reg};
	// a conversion starts only once its channel holds a sample
	assign start_conv = tick && (state_reg == CONV_IDLE) && (active_reg || any_pend)
		&& (held_reg[tgt_chan] || samp_end[tgt_chan]);
	assign done_chan = tick && (state_reg == CONV_TRIAL) && (bit_idx_reg == '0);
	assign pair_done = done_chan && second_reg;

	// shared sample-and-hold arbitration; sequential sampling with order bit 0 holds the odd
	// channel back until its pair has finished the even conversion
	always_comb begin
		sh_any  = 1'b0;
		sh_pick = '0;
		for (int p = NUM_PAIRS - 1; p >= 0; p--) begin
			if (need_reg[2*p+1] && (!sequential_sample_en || conv_order_sel
					|| (active_reg && second_reg && cur_pair_reg == PAIR_W'(p)))) begin
				sh_any  = 1'b1;
				sh_pick = PAIR_W'(p);
			end
		end
	end

	assign sh_grant = tick && !shared_busy_reg && sh_any;

	// per-channel sample timing
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_chan
			logic              start_samp;
			logic [SCNT_W-1:0] samp_cnt_reg;

			if (c % 2 == 0) begin : g_dedicated
				// dedicated circuits ignore order and sequential bits
				assign start_samp = tick && need_reg[c];
			end else begin : g_shared
				assign start_samp = sh_grant && (sh_pick == PAIR_W'(c / 2));
			end

			always_ff @(posedge sys_clk) begin
				if (clr)
					need_reg[c] <= 1'b0;
				else if (trig_ok[c/2])
					need_reg[c] <= 1'b1;
				else if (start_samp)
					need_reg[c] <= 1'b0;
			end

			always_ff @(posedge sys_clk) begin
				if (clr) begin
					samp_reg[c]  <= 1'b0;
					samp_cnt_reg <= '0;
				end else if (start_samp) begin
					samp_reg[c]  <= 1'b1;
					samp_cnt_reg <= '0;
				end else if (tick && samp_reg[c]) begin
					if (samp_cnt_reg == SCNT_W'(SAMPLE_CLKS - 1))
						samp_reg[c] <= 1'b0;
					else
						samp_cnt_reg <= samp_cnt_reg + 1'b1;
				end
			end

			// the last sample tick may already attach, so an idle pair fits in 24 ticks (26 with sequential sampling and order bit 0)
			assign samp_end[c] = tick && samp_reg[c]
				&& samp_cnt_reg == SCNT_W'(SAMPLE_CLKS - 1);

			// a conversion taking the sample this very tick must not leave it held
			always_ff @(posedge sys_clk) begin
				if (clr)
					held_reg[c] <= 1'b0;
				else if (start_conv && tgt_chan == CH_W'(c))
					held_reg[c] <= 1'b0;
				else if (samp_end[c])
					held_reg[c] <= 1'b1;
			end
		end
	endgenerate

	// shared circuit stays occupied from its sample until that conversion ends
	always_ff @(posedge sys_clk) begin
		if (clr)
			shared_busy_reg <= 1'b0;
		else if (sh_grant)
			shared_busy_reg <= 1'b1;
		else if (done_chan && chan_reg[0])
			shared_busy_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (clr)
			pend_reg <= '0;
		else
			for (int p = 0; p < NUM_PAIRS; p++) begin
				if (trig_ok[p])
					pend_reg[p] <= 1'b1;
				else if (pair_done && cur_pair_reg == PAIR_W'(p))
					pend_reg[p] <= 1'b0;
			end
	end

	// pair service: both channels before the next pair is looked at
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			active_reg   <= 1'b0;
			second_reg   <= 1'b0;
			cur_pair_reg <= '0;
		end else if (start_conv) begin
			active_reg   <= 1'b1;
			cur_pair_reg <= sel_pair;
		end else if (done_chan) begin
			active_reg <= ~second_reg;
			second_reg <= ~second_reg;
		end
	end

	// successive approximation: the start tick attaches the channel, then
	// one trial per converter clock from the top bit down
	always_comb begin
		trial_next = trial_reg;
		if (!comp_sync_reg)
			trial_next[bit_idx_reg] = 1'b0;
		if (bit_idx_reg != '0)
			trial_next[bit_idx_reg - 1'b1] = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (clr) begin
			state_reg   <= CONV_IDLE;
			chan_reg    <= '0;
			trial_reg   <= '0;
			bit_idx_reg <= '0;
		end else if (tick) begin
			unique case (state_reg)
				CONV_IDLE: begin
					if (start_conv) begin
						state_reg   <= CONV_TRIAL;
						chan_reg    <= tgt_chan;
						trial_reg   <= TRIAL_FIRST;
						bit_idx_reg <= BIT_IDX_W'(TRIAL_CLKS - 1);
					end
				end
				CONV_TRIAL: begin
					trial_reg <= trial_next;
					if (bit_idx_reg == '0)
						state_reg <= CONV_IDLE;
					else
						bit_idx_reg <= bit_idx_reg - 1'b1;
				end
			endcase
		end
	end

	// result buffers are not cleared by reset and hold stale data until written
	always_ff @(posedge sys_clk) begin
		if (done_chan)
			result_buffer[chan_reg] <= trial_next;
	end

	// set wins over a clear arriving in the same cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ready_reg <= '0;
		else
			for (int p = 0; p < NUM_PAIRS; p++)
				ready_reg[p] <= (pair_done && cur_pair_reg == PAIR_W'(p))
					|| (ready_reg[p] && !pair_ready_clear[p]);
	end

	// read path formats on the fly
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_data  <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				if (result_format_sel == FORMAT_INTEGER)
					rd_data <= {{FRAC_PAD{1'b0}}, result_buffer[rd_sel]};
				else
					rd_data <= {result_buffer[rd_sel], {FRAC_PAD{1'b0}}};
			end
		end
	end

	assign sample_hold_en    = samp_reg;
	assign conv_chan_sel     = chan_reg;
	assign sar_trial_code    = trial_reg;
	assign conv_busy         = (state_reg == CONV_TRIAL);
	assign pair_pending      = pend_reg;
	assign pair_ready_status = ready_reg;

endmodule

`default_nettype wire

// ---- verification/apscs_core_checker.sv ----
// port-level assertions for the pair converter sequencer
`timescale 1ns/1ps
`default_nettype none
module apscs_core_checker
	import apscs_pkg::*;
#(
	parameter int unsigned NUM_PAIRS = DEF_PAIRS
) (
	input wire logic                           sys_clk,
	input wire logic                           sys_rst,
	input wire logic [CTRL_W-1:0]              converter_control_reg,
	input wire logic [NUM_PAIRS-1:0]           pair_trigger,
	input wire logic [NUM_PAIRS-1:0]           pair_ready_clear,
	input wire logic                           comp_in,
	input wire logic                           rd_en,
	input wire logic [$clog2(2*NUM_PAIRS)-1:0] rd_sel,
	input wire logic [BUS_W-1:0]               rd_data,
	input wire logic                           rd_valid,
	input wire logic [2*NUM_PAIRS-1:0]         sample_hold_en,
	input wire logic [$clog2(2*NUM_PAIRS)-1:0] conv_chan_sel,
	input wire logic [RESULT_W-1:0]            sar_trial_code,
	input wire logic                           conv_busy,
	input wire logic [NUM_PAIRS-1:0]           pair_pending,
	input wire logic [NUM_PAIRS-1:0]           pair_ready_status
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// window figures below hold only for a three-cycle converter tick
	wire logic tick3 = converter_control_reg[2:0] == 3'h2;
	chk_even_sample_window: assert property ($rose(sample_hold_en[0]) && tick3 |-> sample_hold_en[0][*6] ##1 !sample_hold_en[0]) else $error("even sample window wrong");
	chk_odd_sample_window: assert property ($rose(sample_hold_en[1]) && tick3 |-> sample_hold_en[1][*6] ##1 !sample_hold_en[1]) else $error("shared sample window wrong");
	chk_dedicated_now: assert property ($rose(pair_pending[0]) |-> ##[0:3] sample_hold_en[0]) else $error("dedicated sample late");
	chk_idle_pair_span: assert property ($rose(pair_pending[0]) && $past(pair_pending) == '0 && tick3 && (!converter_control_reg[5] || converter_control_reg[6]) |-> ##[70:72] $fell(pair_pending[0])) else $error("pair span wrong");
	chk_ready_on_done: assert property ($fell(pair_pending[0]) && $past(converter_control_reg[15]) |-> pair_ready_status[0]) else $error("ready missing");
	chk_pair_zero_first: assert property (conv_busy && pair_pending[0] |-> conv_chan_sel < 2) else $error("priority broken");
	chk_no_repeat: assert property (pair_pending == '0 && $past(pair_pending) == '0 |-> !conv_busy) else $error("converted with nothing pending");
	chk_read_latency: assert property (rd_valid == $past(rd_en)) else $error("read answer timing wrong");
	chk_integer_read: assert property (rd_valid && !$past(converter_control_reg[8]) |-> rd_data[15:10] == 6'h00) else $error("integer read not right-justified");
	chk_fraction_read: assert property (rd_valid && $past(converter_control_reg[8]) |-> rd_data[5:0] == 6'h00) else $error("fraction read not left-justified");
	cov_odd_first: cover property ($rose(conv_busy) && conv_chan_sel == 1);
	cov_last_pair: cover property ($fell(pair_pending[NUM_PAIRS-1]));
	cov_frac_read: cover property (rd_valid && converter_control_reg[8]);
endmodule
bind apscs_core apscs_core_checker #(.NUM_PAIRS(NUM_PAIRS)) chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.converter_control_reg(converter_control_reg), .pair_trigger(pair_trigger),
	.pair_ready_clear(pair_ready_clear), .comp_in(comp_in), .rd_en(rd_en), .rd_sel(rd_sel),
	.rd_data(rd_data), .rd_valid(rd_valid), .sample_hold_en(sample_hold_en),
	.conv_chan_sel(conv_chan_sel), .sar_trial_code(sar_trial_code), .conv_busy(conv_busy),
	.pair_pending(pair_pending), .pair_ready_status(pair_ready_status));
`default_nettype wire

// ---- verification/apscs_analog_model.sv ----
// far side: timer-style trigger sources and per-channel analog levels
`timescale 1ns/1ps
`default_nettype none
module apscs_analog_model
	import apscs_pkg::*;
#(
	parameter int unsigned NUM_PAIRS = DEF_PAIRS
) (
	input  wire logic                                  sys_clk,
	input  wire logic [NUM_PAIRS-1:0]                  trig_req,
	input  wire logic [2*NUM_PAIRS-1:0][RESULT_W-1:0]  chan_level,
	input  wire logic [$clog2(2*NUM_PAIRS)-1:0]        conv_chan_sel,
	input  wire logic [RESULT_W-1:0]                   sar_trial_code,
	output logic      [NUM_PAIRS-1:0]                  pair_trigger,
	output logic                                       comp_in
);
	logic [NUM_PAIRS-1:0] req_reg = '0;
	// a match event is one pulse however long the request stays up
	always_ff @(posedge sys_clk) begin
		req_reg <= trig_req;
		pair_trigger <= trig_req & ~req_reg;
	end
	// no delay here: the design's two sync flops must settle before the next tick
	assign comp_in = chan_level[conv_chan_sel] >= sar_trial_code;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench: sampling modes, conversion order, read formats
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import apscs_pkg::*;
	localparam int NP = 4;
	logic                        sys_clk = 1'b0;
	logic                        sys_rst = 1'b1;
	logic [CTRL_W-1:0]           ctrl = '0;
	logic [NP-1:0]               trig_req = '0;
	logic [NP-1:0]               clr = '0;
	logic                        rd_en = 1'b0;
	logic [2:0]                  rd_sel = '0;
	logic [2*NP-1:0][RESULT_W-1:0] lvl = '0;
	logic                        busy_d = 1'b0;
	logic [2:0]                  chan_d = '0;
	wire logic                   comp_in, rd_valid, conv_busy;
	wire logic [NP-1:0]          pair_trigger, pend, rdy;
	wire logic [BUS_W-1:0]       rd_data;
	wire logic [2*NP-1:0]        shen;
	wire logic [2:0]             chan;
	wire logic [RESULT_W-1:0]    trial;
	int                          failures = 0;
	int                          total_checks = 0;
	int                          seed = 30956;
	logic [2:0]                  chan_q[$];
	logic [BUS_W-1:0]            data_q[$];
	always #12.5 sys_clk = ~sys_clk;
	apscs_core #(.NUM_PAIRS(NP)) apscs_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.converter_control_reg(ctrl), .pair_trigger(pair_trigger), .pair_ready_clear(clr),
		.comp_in(comp_in), .rd_en(rd_en), .rd_sel(rd_sel), .rd_data(rd_data),
		.rd_valid(rd_valid), .sample_hold_en(shen), .conv_chan_sel(chan),
		.sar_trial_code(trial), .conv_busy(conv_busy), .pair_pending(pend),
		.pair_ready_status(rdy));
	apscs_analog_model #(.NUM_PAIRS(NP)) apscs_analog_model_i (.sys_clk(sys_clk),
		.trig_req(trig_req), .chan_level(lvl), .conv_chan_sel(chan),
		.sar_trial_code(trial), .pair_trigger(pair_trigger), .comp_in(comp_in));
	task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// each conversion start and each read answer takes the oldest note
	always @(posedge sys_clk) begin
		if (!sys_rst && conv_busy === 1'b1 && (!busy_d || chan !== chan_d)) begin
			if (chan_q.size() == 0) check(BUS_W'(1), BUS_W'(0));
			else check(BUS_W'(chan), BUS_W'(chan_q.pop_front()));
		end
		if (!sys_rst && rd_valid === 1'b1) begin
			if (data_q.size() == 0) check(BUS_W'(1), BUS_W'(0));
			else check(rd_data, data_q.pop_front());
		end
		busy_d = conv_busy;
		chan_d = chan;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		print_verdict();
	end
	initial begin
		logic [CTRL_W-1:0] cw;
		int c;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			cw = 16'h8002;
			cw[CTRL_ORDER_BIT] = m[0];
			cw[CTRL_SEQ_BIT] = m[1];
			cw[CTRL_FORMAT_BIT] = m[0] ^ m[1];
			// configure and clear status with the module off, then switch on
			@(posedge sys_clk);
			ctrl <= cw & 16'h7fff;
			clr <= '1;
			for (c = 0; c < 2 * NP; c++) begin
				lvl[c] <= RESULT_W'($random(seed));
				chan_q.push_back(3'(c ^ m[0]));
			end
			if (m == 0) begin
				lvl[0] <= 10'h000;
				lvl[1] <= 10'h3ff;
			end
			@(posedge sys_clk);
			clr <= '0;
			ctrl <= cw;
			@(posedge sys_clk);
			check(BUS_W'(rdy), BUS_W'(0));
			trig_req <= '1;
			@(posedge sys_clk);
			trig_req <= '0;
			@(posedge sys_clk);
			trig_req <= 4'h1;
			@(posedge sys_clk);
			trig_req <= '0;
			c = 0;
			while (pend !== '0 && c < 2000) begin
				@(posedge sys_clk);
				c++;
			end
			if (c >= 2000) failures++;
			repeat (10) @(posedge sys_clk);
			check(BUS_W'(rdy), BUS_W'(4'hf));
			check(BUS_W'(chan_q.size()), BUS_W'(0));
			for (c = 0; c < 2 * NP; c++) begin
				@(posedge sys_clk);
				rd_en <= 1'b1;
				rd_sel <= 3'(c);
				data_q.push_back(ctrl[CTRL_FORMAT_BIT] ? {lvl[c], 6'h00} : {6'h00, lvl[c]});
			end
			@(posedge sys_clk);
			rd_en <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
		check(BUS_W'(data_q.size()), BUS_W'(0));
		print_verdict();
	end
endmodule
`default_nettype wire
